// ### core/stcr_regs.sv
// supervisor threshold, retry/sync and power-good mask configuration registers
`timescale 1ns/1ns
`include "stcr_map.svh"
module stcr_regs
    import stcr_pkg::*;
#(
    parameter stcr_count_t P_GOOD_DELAY_CYC = 20'(`STCR_GOOD_DELAY_CYC)
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_fuse_sync_out,
    input wire logic i_fuse_retry_off,
    input wire logic i_fuse_good_include,
    input wire logic [7:0] i_junction_temp,
    input wire logic [7:0] i_vin_level,
    input wire logic [3:0] i_ch_good,
    input wire logic [1:0] i_flag_clr,
    input wire logic [1:0] i_flag_mask,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_sync_is_output,
    output logic [3:0] o_retry_protect_disable,
    output logic [3:0] o_short_protect_disable,
    output logic o_supply_good_out,
    output logic o_overheat_flag,
    output logic o_low_input_flag,
    output logic o_fault_alert_n
);
    stcr_byte_t warning_threshold_config_reg;
    stcr_byte_t hiccup_and_sync_config_reg;
    stcr_byte_t power_good_channel_mask_reg;
    stcr_byte_t rd_data_next;

    function automatic stcr_byte_t temp_limit(input logic [1:0] sel);
        temp_limit = (sel == 2'd1) ? `STCR_OT_LEVEL1 : (sel == 2'd2) ? `STCR_OT_LEVEL2 : `STCR_OT_LEVEL3;
    endfunction

    function automatic stcr_byte_t vin_limit(input logic [3:0] sel);
        vin_limit = `STCR_LV_BASE + 8'(sel) * `STCR_LV_STEP;
    endfunction

    wire logic [1:0] overheat_threshold_sel = warning_threshold_config_reg[`STCR_OT_MSB:`STCR_OT_LSB];
    wire logic [3:0] low_input_threshold_sel = warning_threshold_config_reg[`STCR_LV_MSB:`STCR_LV_LSB];
    wire stcr_chan_t good_include = power_good_channel_mask_reg[`STCR_CH_MSB:0];

    wire logic ot_enabled = (overheat_threshold_sel != `STCR_OT_OFF_CODE); // RULE_02
    wire logic lv_enabled = (low_input_threshold_sel != `STCR_LV_OFF_CODE); // RULE_04
    wire logic ot_cross = ot_enabled && (i_junction_temp > temp_limit(overheat_threshold_sel)); // RULE_01
    wire logic lv_cross = lv_enabled && (i_vin_level < vin_limit(low_input_threshold_sel)); // RULE_03

    // set wins over a clear in the same cycle
    wire logic overheat_next = ot_cross || (o_overheat_flag && !i_flag_clr[0]); // RULE_05
    wire logic low_input_flag_next = lv_cross || (o_low_input_flag && !i_flag_clr[1]); // RULE_05
    wire logic alert_n_next = !((overheat_next && !i_flag_mask[0]) || (low_input_flag_next && !i_flag_mask[1])); // RULE_13

    // excluded channels count as good, so an all-masked bank reads good
    wire logic good_and = &(i_ch_good | ~good_include); // RULE_09 RULE_10

    wire logic wr_warn = i_wr_en && (i_addr == `STCR_ADDR_WARN);
    wire logic wr_hiccup = i_wr_en && (i_addr == `STCR_ADDR_HICCUP);
    wire logic wr_mask = i_wr_en && (i_addr == `STCR_ADDR_MASK);

    // reserved bits stored as written but routed nowhere
    always_comb begin
        if (i_addr == `STCR_ADDR_WARN) begin
            rd_data_next = warning_threshold_config_reg; // RULE_14
        end else if (i_addr == `STCR_ADDR_HICCUP) begin
            rd_data_next = hiccup_and_sync_config_reg;
        end else if (i_addr == `STCR_ADDR_MASK) begin
            rd_data_next = power_good_channel_mask_reg;
        end else begin
            rd_data_next = 8'h00;
        end
    end

    // fuses are sampled on every synchronous reset cycle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            warning_threshold_config_reg <= `STCR_WARN_RESET; // RULE_02
            hiccup_and_sync_config_reg <= {i_fuse_sync_out, 3'h0, {4{i_fuse_retry_off}}}; // RULE_08
            power_good_channel_mask_reg <= {4'h0, {4{i_fuse_good_include}}}; // RULE_12
        end else begin
            if (wr_warn) begin
                warning_threshold_config_reg <= i_wr_data;
            end
            if (wr_hiccup) begin
                hiccup_and_sync_config_reg <= i_wr_data;
            end
            if (wr_mask) begin
                power_good_channel_mask_reg <= i_wr_data;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rd_data <= 8'h00;
            o_rd_valid <= 1'b0;
            o_sync_is_output <= 1'b0;
            o_retry_protect_disable <= 4'h0;
            o_short_protect_disable <= 4'h0;
            o_overheat_flag <= 1'b0;
            o_low_input_flag <= 1'b0;
            o_fault_alert_n <= 1'b1;
        end else begin
            o_rd_data <= i_rd_en ? rd_data_next : o_rd_data;
            o_rd_valid <= i_rd_en;
            o_sync_is_output <= hiccup_and_sync_config_reg[`STCR_SYNC_BIT]; // RULE_06
            o_retry_protect_disable <= hiccup_and_sync_config_reg[`STCR_CH_MSB:0]; // RULE_07
            o_short_protect_disable <= hiccup_and_sync_config_reg[`STCR_CH_MSB:0]; // RULE_07
            o_overheat_flag <= overheat_next;
            o_low_input_flag <= low_input_flag_next;
            o_fault_alert_n <= alert_n_next;
        end
    end

    stcr_good_delay #(
        .P_DELAY_CYC(P_GOOD_DELAY_CYC)
    ) u_good_delay (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_cond(good_and),
        .o_good(o_supply_good_out)
    );

    AST_OT_SETS: assert property (@(posedge i_clk) disable iff (i_srst) ot_cross |=> o_overheat_flag) // RULE_01
        else $error("overheat crossing did not set the flag");
    AST_OT_OFF: assert property (@(posedge i_clk) disable iff (i_srst)
        (overheat_threshold_sel == 2'h0) && !o_overheat_flag |=> !o_overheat_flag) // RULE_02
        else $error("overheat flag set while warning disabled");
    AST_LV_SETS: assert property (@(posedge i_clk) disable iff (i_srst)
        lv_enabled && (i_vin_level < 8'h2a + 8'(low_input_threshold_sel) * 8'h05) |=> o_low_input_flag) // RULE_03
        else $error("low input crossing did not set the flag");
    AST_LV_OFF: assert property (@(posedge i_clk) disable iff (i_srst)
        (low_input_threshold_sel == 4'hf) && !o_low_input_flag |=> !o_low_input_flag) // RULE_04
        else $error("low input flag set while warning disabled");
    AST_FLAG_HOLDS: assert property (@(posedge i_clk) disable iff (i_srst)
        o_overheat_flag && !i_flag_clr[0] |=> o_overheat_flag) // RULE_05
        else $error("overheat flag lost without a clear");
    AST_SYNC_DIR: assert property (@(posedge i_clk) disable iff (i_srst)
        wr_hiccup ##1 !i_srst |=> o_sync_is_output == $past(i_wr_data[7], 2)) // RULE_06
        else $error("sync direction does not follow written bit");
    AST_SHORT_FOLLOWS: assert property (@(posedge i_clk) disable iff (i_srst)
        ##1 o_short_protect_disable == o_retry_protect_disable) // RULE_07
        else $error("short protect disable differs from retry disable");
    AST_FUSE_RETRY: assert property (@(posedge i_clk)
        i_srst |=> hiccup_and_sync_config_reg == {$past(i_fuse_sync_out), 3'h0, {4{$past(i_fuse_retry_off)}}}) // RULE_08
        else $error("retry and sync reset value ignores fuses");
    AST_FUSE_MASK: assert property (@(posedge i_clk)
        i_srst |=> power_good_channel_mask_reg == {4'h0, {4{$past(i_fuse_good_include)}}}) // RULE_12
        else $error("mask reset value ignores fuse");
    AST_ALERT: assert property (@(posedge i_clk) disable iff (i_srst)
        o_overheat_flag && !i_flag_mask[0] && !i_flag_clr[0] |=> !o_fault_alert_n) // RULE_13
        else $error("alert not asserted for unmasked flag");
    AST_MASKED_BAD: assert property (@(posedge i_clk) disable iff (i_srst)
        |(~i_ch_good & good_include) |=> !o_supply_good_out) // RULE_09
        else $error("included bad channel did not pull power-good low");
    AST_RSVD_READ: assert property (@(posedge i_clk) disable iff (i_srst)
        wr_mask ##1 (i_rd_en && i_addr == 8'h0b && !i_wr_en) |=> o_rd_data == $past(i_wr_data, 2)) // RULE_14
        else $error("read-back differs from written byte");

    AST_RD_VALID: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_14
        i_rd_en |=> o_rd_valid)
        else $error("read strobe gave no valid pulse");

    AST_RD_IDLE: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_14
        !i_rd_en |=> !o_rd_valid)
        else $error("valid pulse without a read strobe");

    AST_RD_HOLDS: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_14
        !i_rd_en |=> $stable(o_rd_data))
        else $error("read data changed without a read");

    AST_UNMAPPED_READ: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_14
        i_rd_en && (i_addr < 8'h09 || i_addr > 8'h0b) |=> o_rd_data == 8'h00)
        else $error("unmapped read returned nonzero data");

    AST_WARN_WRITE: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_14
        wr_warn |=> warning_threshold_config_reg == $past(i_wr_data))
        else $error("threshold register did not take the written byte");

    AST_HICCUP_WRITE: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_14
        wr_hiccup |=> hiccup_and_sync_config_reg == $past(i_wr_data))
        else $error("retry register did not take the written byte");

    AST_MASK_WRITE: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_14
        wr_mask |=> power_good_channel_mask_reg == $past(i_wr_data))
        else $error("mask register did not take the written byte");

    AST_UNMAPPED_WRITE: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_14
        i_wr_en && (i_addr < 8'h09 || i_addr > 8'h0b) |=> $stable(warning_threshold_config_reg))
        else $error("unmapped write changed the threshold register");

    AST_LV_HOLDS: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_05
        o_low_input_flag && !i_flag_clr[1] |=> o_low_input_flag)
        else $error("low input flag lost without a clear");

    AST_SET_WINS: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_05
        ot_cross && i_flag_clr[0] |=> o_overheat_flag)
        else $error("clear beat a same-cycle overheat crossing");

    AST_FLAG_CLEARS: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_05
        o_overheat_flag && i_flag_clr[0] && !ot_cross |=> !o_overheat_flag)
        else $error("overheat flag survived a clear");

    AST_ALERT_IDLE: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_13
        !overheat_next && !low_input_flag_next |=> o_fault_alert_n)
        else $error("alert low with no flag set");

    AST_RETRY_FOLLOWS: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_07
        1'b1 |=> o_retry_protect_disable == $past(hiccup_and_sync_config_reg[`STCR_CH_MSB:0]))
        else $error("retry disable output does not follow the register");

    AST_LV_ALERT: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_13
        o_low_input_flag && !i_flag_mask[1] && !i_flag_clr[1] |=> !o_fault_alert_n)
        else $error("alert not asserted for unmasked low input flag");
endmodule

// ### core/stcr_map.svh
// register map, field positions, reset values and timing of the supervisor threshold config bank
// Operation
// RULE_01 - overheat select bits 5:4 pick warning level 105, 115 or 125 degrees C
// RULE_02 - overheat select 00 disables the temperature warning and is the reset value
// RULE_03 - low-input select bits 3:0 decode 4.2 V plus 0.5 V per step, up to 11.2 V
// RULE_04 - low-input select 1111 disables the low input voltage warning
// RULE_05 - enabled threshold crossed sets the overheat or low-input flag
// RULE_06 - hiccup register bit 7 sets sync pin direction, 1 drives clock out
// RULE_07 - bits 3:0 disable per-channel retry protection and also short-circuit protection
// RULE_08 - sync direction and retry-disable reset values come from factory fuses
// RULE_09 - mask bits 3:0 include a channel's power-good in the output when 1
// RULE_10 - power-good output is the AND of all included channel power-good signals
// RULE_11 - power-good output rises only after the AND held true for 1 ms
// RULE_12 - the four include bits reset together from one factory fuse choice
// RULE_13 - active-low fault alert pulled low while any unmasked flag is set
// RULE_14 - reserved bits are read-write, reset to zero, and steer nothing
`ifndef STCR_MAP_SVH
`define STCR_MAP_SVH

`define STCR_ADDR_WARN 8'h09
`define STCR_ADDR_HICCUP 8'h0a
`define STCR_ADDR_MASK 8'h0b

`define STCR_OT_MSB 5
`define STCR_OT_LSB 4
`define STCR_LV_MSB 3
`define STCR_LV_LSB 0
`define STCR_SYNC_BIT 7
`define STCR_CH_MSB 3

`define STCR_WARN_RESET 8'h00
`define STCR_LV_OFF_CODE 4'hf
`define STCR_OT_OFF_CODE 2'h0

// temperatures in degrees C, voltages in tenths of a volt
`define STCR_OT_LEVEL1 8'h69
`define STCR_OT_LEVEL2 8'h73
`define STCR_OT_LEVEL3 8'h7d
`define STCR_LV_BASE 8'h2a
`define STCR_LV_STEP 8'h05

`define STCR_CLK_PERIOD_NS 4
`define STCR_GOOD_DELAY_NS 1000000
`define STCR_GOOD_DELAY_CYC (`STCR_GOOD_DELAY_NS / `STCR_CLK_PERIOD_NS)

`endif

// ### core/stcr_pkg.sv
// types shared by the supervisor threshold config bank
package stcr_pkg;
    typedef logic [7:0] stcr_byte_t;
    typedef logic [3:0] stcr_chan_t;
    typedef logic [19:0] stcr_count_t;
endpackage

// ### core/stcr_good_delay.sv
// power-good validation delay: output rises after the input held true for the delay
`timescale 1ns/1ns
module stcr_good_delay
    import stcr_pkg::*;
#(
    parameter stcr_count_t P_DELAY_CYC = 20'd250000
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_cond,
    output logic o_good
);
    stcr_count_t count_reg;
    stcr_count_t count_next;
    logic good_next;
    wire logic done = (count_reg == P_DELAY_CYC - 20'd1);

    // any drop restarts the full wait, no partial credit
    assign count_next = !i_cond ? 20'd0 : (done ? count_reg : count_reg + 20'd1); // RULE_11
    assign good_next = i_cond && (o_good || done); // RULE_10

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            count_reg <= 20'd0;
            o_good <= 1'b0;
        end else begin
            count_reg <= count_next;
            o_good <= good_next;
        end
    end

    AST_GOOD_DROPS: assert property (@(posedge i_clk) disable iff (i_srst) !i_cond |=> !o_good) // RULE_10
        else $error("power-good output stayed high after condition fell");
    AST_GOOD_WAITS: assert property (@(posedge i_clk) disable iff (i_srst) $rose(i_cond) |=> !o_good [*8]) // RULE_11
        else $error("power-good output rose before the validation delay");
endmodule

// ### tb/stcr_host_model.sv
// host-side strobe master model for the config register port
`timescale 1ns/1ns
module stcr_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wr_data
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h00;
        o_wr_data = 8'h00;
    end
    // idle bus shows inverted values so a stale address never passes as valid
    task automatic release_bus();
        o_addr = ~o_addr;
        o_wr_data = ~o_wr_data;
    endtask
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1 o_wr_en = 1'b1;
        o_addr = a;
        o_wr_data = d;
        @(posedge i_clk);
        #1 o_wr_en = 1'b0;
        release_bus();
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] q, output logic v);
        @(posedge i_clk);
        #1 o_rd_en = 1'b1;
        o_addr = a;
        @(posedge i_clk);
        #1 o_rd_en = 1'b0;
        release_bus();
        v = i_rd_valid;
        q = i_rd_data;
    endtask
endmodule

// ### tb/test_stcr_regs.sv
// self-checking bench for the supervisor threshold config registers
`timescale 1ns/1ns
module test_stcr_regs;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic f_sync = 1'b1;
    logic f_retry = 1'b0;
    logic f_inc = 1'b1;
    logic wr_en, rd_en, rd_valid, sync_o, good, ot, lv, alert_n, v;
    logic [7:0] addr, wr_data, rd_data, q;
    logic [7:0] temp = 8'h00;
    logic [7:0] vin = 8'hff;
    logic [3:0] ch_good = 4'h0;
    logic [3:0] retry, short_d;
    logic [1:0] clr = 2'h0;
    logic [1:0] msk = 2'h0;
    int miscompares = 0;
    int num_checks = 0;
    // rows: warning byte, temperature, input level, expected {low_input, overheat}
    logic [25:0] rows [8] = '{{8'h00, 8'hc8, 8'hff, 2'b00}, {8'h10, 8'h6a, 8'h2a, 2'b01},
        {8'h10, 8'h69, 8'h29, 2'b10}, {8'h2e, 8'h74, 8'h70, 2'b01}, {8'h2e, 8'h73, 8'h6f, 2'b10},
        {8'h3f, 8'h7e, 8'h00, 2'b01}, {8'h30, 8'h7d, 8'hff, 2'b00}, {8'hc1, 8'h00, 8'h2e, 2'b10}};
    always #2 clk = ~clk;
    stcr_host_model host_u (.i_clk(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .o_wr_en(wr_en),
        .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wr_data));
    stcr_regs #(.P_GOOD_DELAY_CYC(20'h0_000a)) dut_u (.i_clk(clk), .i_srst(srst), .i_wr_en(wr_en),
        .i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wr_data), .i_fuse_sync_out(f_sync),
        .i_fuse_retry_off(f_retry), .i_fuse_good_include(f_inc), .i_junction_temp(temp), .i_vin_level(vin),
        .i_ch_good(ch_good), .i_flag_clr(clr), .i_flag_mask(msk), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
        .o_sync_is_output(sync_o), .o_retry_protect_disable(retry), .o_short_protect_disable(short_d),
        .o_supply_good_out(good), .o_overheat_flag(ot), .o_low_input_flag(lv), .o_fault_alert_n(alert_n));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host_u.read(a, q, v);
        chk({7'h00, v}, 8'h01);
        chk(q, exp);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rst(input logic s, input logic r, input logic g);
        f_sync = s;
        f_retry = r;
        f_inc = g;
        srst = 1'b1;
        step(3);
        srst = 1'b0;
        step(1);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        rst(1'b1, 1'b0, 1'b1);
        chk(sync_o, 1'b1);
        chk(retry, 4'h0);
        rdchk(8'h09, 8'h00);
        rdchk(8'h0a, 8'h80);
        rdchk(8'h0b, 8'h0f);
        // second reset mid-run with the opposite fuse choices
        rst(1'b0, 1'b1, 1'b0);
        chk(sync_o, 1'b0);
        chk(short_d, 4'hf);
        rdchk(8'h0a, 8'h0f);
        rdchk(8'h0b, 8'h00);
        rdchk(8'h0c, 8'h00);
        host_u.write(8'h0a, 8'hf5);
        step(2);
        chk(sync_o, 1'b1);
        chk(retry, 4'h5);
        chk(short_d, 4'h5);
        rdchk(8'h0a, 8'hf5);
        for (int i = 0; i < 8; i++) begin
            temp = 8'h00;
            vin = 8'hff;
            clr = 2'h3;
            msk = i[1:0];
            host_u.write(8'h09, rows[i][25:18]);
            clr = 2'h0;
            temp = rows[i][17:10];
            vin = rows[i][9:2];
            step(2);
            chk(ot, rows[i][0]);
            chk(lv, rows[i][1]);
            chk(alert_n, !(|(rows[i][1:0] & ~msk)));
            rdchk(8'h09, rows[i][25:18]);
        end
        // crossing still present: a clear must lose, then win once the crossing goes
        clr = 2'h2;
        step(1);
        clr = 2'h0;
        chk(lv, 1'b1);
        vin = 8'hff;
        clr = 2'h2;
        step(1);
        clr = 2'h0;
        step(1);
        chk(lv, 1'b0);
        // channels 1 and 3 included; failing channels 2 and 4 must not matter
        host_u.write(8'h0b, 8'h05);
        ch_good = 4'b1010;
        step(3);
        chk(good, 1'b0);
        ch_good = 4'b0101;
        step(8);
        chk(good, 1'b0);
        step(4);
        chk(good, 1'b1);
        ch_good = 4'b0100;
        step(2);
        chk(good, 1'b0);
        complete_run();
    end
    initial begin
        #20000;
        miscompares++;
        complete_run();
    end
endmodule
